// [common/fsr_cfg.svh]
// Constants of the fault and status register bank: command codes,
// supported-bit layouts and reset values of the alert masks.
// Assumes nothing; included by the package and by the bank.
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// Command codes
`define FSR_CMD_CLEAR_FAULTS   8'h03
`define FSR_CMD_ALERT_MASK     8'h1B
`define FSR_CMD_SUMMARY_BYTE   8'h78
`define FSR_CMD_SUMMARY_WORD   8'h79
`define FSR_CMD_VOUT_STS       8'h7A
`define FSR_CMD_IOUT_STS       8'h7B
`define FSR_CMD_INPUT_STS      8'h7C
`define FSR_CMD_TEMP_STS       8'h7D
`define FSR_CMD_CML_STS        8'h7E
`define FSR_CMD_MAKER_STS      8'h80
`define FSR_CMD_FAULT_LOG_CLR  8'hEC
`define FSR_CMD_PAD_STATE      8'hE5
`define FSR_CMD_COMMON_STS     8'hEF

// Supported, alertable and sticky bits of the status bytes
`define FSR_VOUT_SUPPORT       8'hFE
`define FSR_IOUT_SUPPORT       8'hA0
`define FSR_INPUT_SUPPORT      8'hAA
`define FSR_INPUT_ALERTABLE    8'h80
`define FSR_TEMP_SUPPORT       8'hD0
`define FSR_CML_SUPPORT        8'hFF
`define FSR_MAKER_SHARED       8'hFC
`define FSR_MAKER_PAGED        8'h01
`define FSR_MAKER_STICKY       8'h08

// Field positions
`define FSR_LOG_BIT            3
`define FSR_PLL_BIT            4

// Alert mask reset values
`define FSR_MASK_RST           8'h00
`define FSR_MAKER_MASK_RST     8'h11

`endif

// [common/fsr_pkg.sv]
// Command code type of the fault and status register bank, used by its bench.
// Assumes fsr_cfg.svh is on the include path.
`include "fsr_cfg.svh"

package fsr_pkg;

   typedef enum logic [7:0] {
      CMD_CLEAR_FAULTS  = `FSR_CMD_CLEAR_FAULTS,
      CMD_ALERT_MASK    = `FSR_CMD_ALERT_MASK,
      CMD_SUMMARY_BYTE  = `FSR_CMD_SUMMARY_BYTE,
      CMD_SUMMARY_WORD  = `FSR_CMD_SUMMARY_WORD,
      CMD_VOUT_STS      = `FSR_CMD_VOUT_STS,
      CMD_IOUT_STS      = `FSR_CMD_IOUT_STS,
      CMD_INPUT_STS     = `FSR_CMD_INPUT_STS,
      CMD_TEMP_STS      = `FSR_CMD_TEMP_STS,
      CMD_CML_STS       = `FSR_CMD_CML_STS,
      CMD_MAKER_STS     = `FSR_CMD_MAKER_STS,
      CMD_FAULT_LOG_CLR = `FSR_CMD_FAULT_LOG_CLR,
      CMD_PAD_STATE     = `FSR_CMD_PAD_STATE,
      CMD_COMMON_STS    = `FSR_CMD_COMMON_STS
   } fsr_cmd_t;

endpackage : fsr_pkg

// [rtl/fsr_sync.sv]
// Two-flop synchroniser, one per bit, for pin levels.
// Assumes the inputs are asynchronous to mclk.
`timescale 1ns/10ps

module fsr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinSync
);

   logic [W-1:0] meta_r;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
         if (rst) begin
            meta_r[i]  <= 1'b0;
            pinSync[i] <= 1'b0;
         end else begin
            meta_r[i]  <= pinIn[i];
            pinSync[i] <= meta_r[i];
         end
      end
   end

endmodule : fsr_sync

// [rtl/fsr_w1c_byte.sv]
// One latched status byte: events set bits, write-one and the global
// clear reset non-sticky ones, the sticky clear resets sticky ones, and
// newly set unmasked alertable bits raise an alert event.
// Assumes events and controls come from logic on mclk.
`timescale 1ns/10ps

module fsr_w1c_byte #(
   parameter logic [7:0] SUPPORT   = 8'hFF,
   parameter logic [7:0] ALERTABLE = 8'hFF,
   parameter logic [7:0] STICKY    = 8'h00
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Set and clear
   input  wire logic [7:0] evt,
   input  wire logic       clrAll,
   input  wire logic       clrSticky,
   input  wire logic       w1cEn,
   input  wire logic [7:0] w1cData,
   input  wire logic [7:0] alertMask,
   // State
   output logic      [7:0] sts,
   output logic            alertNew,
   output logic            alertHeld
);

   logic [7:0] setBits;
   logic [7:0] clrBits;
   logic [7:0] liveAlert;

   assign setBits   = evt & SUPPORT;
   assign clrBits   = ({8{clrAll}} & ~STICKY) | ({8{clrSticky}} & STICKY)
                    | ({8{w1cEn}} & w1cData & ~STICKY);
   assign liveAlert = SUPPORT & ALERTABLE & ~alertMask;
   // A fault still present through a clear raises the alert again
   assign alertNew  = |(setBits & liveAlert & (~sts | clrBits));
   assign alertHeld = |(sts & liveAlert);

   // Set wins over any clear in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         sts <= 8'h00;
      end else begin
         sts <= (sts & ~clrBits) | setBits;
      end
   end

   set_wins_a : assert property (@(posedge mclk) disable iff (rst)
      evt[0] && SUPPORT[0] |=> sts[0])
      else $error("status bit lost a set");
   zero_keeps_a : assert property (@(posedge mclk) disable iff (rst)
      (sts[7] && w1cEn && !w1cData[7] && !clrAll) |=> sts[7])
      else $error("writing zero cleared a bit");

endmodule : fsr_w1c_byte

// [rtl/fsr_bank.sv]
// Fault and status register bank of a two-channel power controller.
// Assumes a command engine on mclk presents decoded reads and writes
// and fault events as one-cycle or level signals on mclk; pins synced.
`timescale 1ns/10ps
`include "fsr_cfg.svh"

module fsr_bank (
   // Clock and reset
   input  wire logic            mclk,
   input  wire logic            rst,
   // Command port
   input  wire logic            cmdValid,
   input  wire logic            cmdWrite,
   input  wire logic [7:0]      cmdCode,
   input  wire logic            cmdPage,
   input  wire logic [15:0]     cmdData,
   output logic                 rdValid_r,
   output logic      [15:0]     rdData_r,
   output logic                 alertActive_r,
   // Paged fault events
   input  wire logic [1:0][7:0] voutEvt,
   input  wire logic [1:0][7:0] ioutEvt,
   input  wire logic [1:0][7:0] tempEvt,
   // Shared fault events
   input  wire logic [7:0]      inputEvt,
   input  wire logic [7:0]      cmlEvt,
   input  wire logic [7:0]      makerEvt,
   input  wire logic            busyEvt,
   // Controller levels
   input  wire logic [1:0]      powerGood,
   input  wire logic [1:0]      outputOn,
   input  wire logic            rail3v3Ov,
   input  wire logic            rail3v3Uv,
   input  wire logic            adcInvalid,
   input  wire logic            syncOutOff,
   input  wire logic [1:0]      runDriveLow,
   input  wire logic [1:0]      gpioDriveLow,
   input  wire logic            ctrlBusy,
   input  wire logic            calcPending,
   input  wire logic            outInTransition,
   input  wire logic            nvmInitDone,
   input  wire logic            sharedClkTimeout,
   // Pins
   input  wire logic [1:0]      runPin,
   input  wire logic [1:0]      faultPin,
   input  wire logic            writeProtPin
);

   logic [4:0]      pinSync;
   logic [1:0]      runLvl;
   logic [1:0]      faultLvl;
   logic            wpLvl;
   logic            wrStb;
   logic            clearFaults;
   logic            logClear;
   logic [1:0][7:0] vout;
   logic [1:0][7:0] iout;
   logic [1:0][7:0] temp;
   logic [1:0][7:0] makerPg;
   logic [7:0]      inputSts;
   logic [7:0]      comm_memory_logic_flag;
   logic [7:0]      makerSh;
   logic [1:0][7:0] voutMask_r;
   logic [1:0][7:0] ioutMask_r;
   logic [1:0][7:0] tempMask_r;
   logic [1:0][7:0] makerMask_r;
   logic [7:0]      inputMask_r;
   logic [7:0]      cmlMask_r;
   logic            busySts_r;
   logic [1:0]      extPullEvt;
   logic [1:0]      syncWarm_r;
   logic [7:0]      makerShEvt;
   logic [14:0]     newVec;
   logic [14:0]     heldVec;
   logic            alertNew;
   logic            alertHeld;
   logic [1:0][7:0] sumByte;
   logic [1:0][15:0] sumWord;
   logic [15:0]     padWord;
   logic [7:0]      commonByte;
   logic [7:0]      maskRead;
   logic [15:0]     rdNxt;

   fsr_sync #(.W(5)) u_sync (
      .mclk    (mclk),
      .rst     (rst),
      .pinIn   ({writeProtPin, faultPin, runPin}),
      .pinSync (pinSync)
   );
   assign runLvl   = pinSync[1:0];
   assign faultLvl = pinSync[3:2];
   assign wpLvl    = pinSync[4];

   // Synchronised pins are not yet valid for two cycles after reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         syncWarm_r <= 2'b00;
      end else begin
         syncWarm_r <= {syncWarm_r[0], 1'b1};
      end
   end

   assign wrStb       = cmdValid && cmdWrite;
   assign clearFaults = wrStb && (cmdCode == `FSR_CMD_CLEAR_FAULTS);
   assign logClear    = wrStb && (cmdCode == `FSR_CMD_FAULT_LOG_CLR);

   // Pin held low by someone else while we do not drive it
   assign extPullEvt = ~faultLvl & ~gpioDriveLow & {2{syncWarm_r[1]}};
   assign makerShEvt = {makerEvt[7:3], makerEvt[2] | rail3v3Ov | rail3v3Uv,
                        2'b00};

   for (genvar c = 0; c < 2; c++) begin : g_page
      logic pgWr;
      assign pgWr = wrStb && (cmdPage == 1'(c));

      fsr_w1c_byte #(.SUPPORT(`FSR_VOUT_SUPPORT)) u_vout (
         .mclk (mclk), .rst (rst), .clrAll (clearFaults), .clrSticky (1'b0),
         .evt (voutEvt[c]), .w1cData (cmdData[7:0]),
         .w1cEn (pgWr && cmdCode == `FSR_CMD_VOUT_STS),
         .alertMask (voutMask_r[c]), .sts (vout[c]),
         .alertNew (newVec[c]), .alertHeld (heldVec[c])
      );
      fsr_w1c_byte #(.SUPPORT(`FSR_IOUT_SUPPORT)) u_iout (
         .mclk (mclk), .rst (rst), .clrAll (clearFaults), .clrSticky (1'b0),
         .evt (ioutEvt[c]), .w1cData (cmdData[7:0]),
         .w1cEn (pgWr && cmdCode == `FSR_CMD_IOUT_STS),
         .alertMask (ioutMask_r[c]), .sts (iout[c]),
         .alertNew (newVec[2+c]), .alertHeld (heldVec[2+c])
      );
      fsr_w1c_byte #(.SUPPORT(`FSR_TEMP_SUPPORT)) u_temp (
         .mclk (mclk), .rst (rst), .clrAll (clearFaults), .clrSticky (1'b0),
         .evt (tempEvt[c]), .w1cData (cmdData[7:0]),
         .w1cEn (pgWr && cmdCode == `FSR_CMD_TEMP_STS),
         .alertMask (tempMask_r[c]), .sts (temp[c]),
         .alertNew (newVec[4+c]), .alertHeld (heldVec[4+c])
      );
      fsr_w1c_byte #(.SUPPORT(`FSR_MAKER_PAGED)) u_mkpg (
         .mclk (mclk), .rst (rst), .clrAll (clearFaults), .clrSticky (1'b0),
         .evt ({7'h00, extPullEvt[c]}), .w1cData (cmdData[7:0]),
         .w1cEn (pgWr && cmdCode == `FSR_CMD_MAKER_STS),
         .alertMask (makerMask_r[c]), .sts (makerPg[c]),
         .alertNew (newVec[6+c]), .alertHeld (heldVec[6+c])
      );

      // Summary byte and word per page
      always_comb begin
         sumByte[c] = {busySts_r, ~outputOn[c], vout[c][7], iout[c][7],
                       1'b0, |temp[c], |comm_memory_logic_flag, |inputSts};
         sumWord[c] = {|vout[c], |iout[c], |inputSts,
                       |(makerSh | makerPg[c]), ~powerGood[c], 3'b000,
                       sumByte[c]};
      end
   end

   fsr_w1c_byte #(.SUPPORT(`FSR_INPUT_SUPPORT),
                  .ALERTABLE(`FSR_INPUT_ALERTABLE)) u_input (
      .mclk (mclk), .rst (rst), .clrAll (clearFaults), .clrSticky (1'b0),
      .evt (inputEvt), .w1cData (cmdData[7:0]),
      .w1cEn (wrStb && cmdCode == `FSR_CMD_INPUT_STS),
      .alertMask (inputMask_r), .sts (inputSts),
      .alertNew (newVec[8]), .alertHeld (heldVec[8])
   );
   fsr_w1c_byte #(.SUPPORT(`FSR_CML_SUPPORT)) u_cml (
      .mclk (mclk), .rst (rst), .clrAll (clearFaults), .clrSticky (1'b0),
      .evt (cmlEvt), .w1cData (cmdData[7:0]),
      .w1cEn (wrStb && cmdCode == `FSR_CMD_CML_STS),
      .alertMask (cmlMask_r), .sts (comm_memory_logic_flag),
      .alertNew (newVec[9]), .alertHeld (heldVec[9])
   );
   fsr_w1c_byte #(.SUPPORT(`FSR_MAKER_SHARED),
                  .STICKY(`FSR_MAKER_STICKY)) u_mksh (
      .mclk (mclk), .rst (rst), .clrAll (clearFaults), .clrSticky (logClear),
      .evt (makerShEvt), .w1cData (cmdData[7:0]),
      .w1cEn (wrStb && cmdCode == `FSR_CMD_MAKER_STS),
      .alertMask (makerMask_r[0] & makerMask_r[1]), .sts (makerSh),
      .alertNew (newVec[10]), .alertHeld (heldVec[10])
   );
   assign newVec[14:11]  = {3'b000, busyEvt && !busySts_r};
   assign heldVec[14:11] = {3'b000, busySts_r};

   // Busy fault of the summary byte
   always_ff @(posedge mclk) begin
      if (rst) begin
         busySts_r <= 1'b0;
      end else begin
         busySts_r <= busyEvt || (busySts_r && !clearFaults);
      end
   end

   // Alert mask settings: data low byte names register, high byte mask
   always_ff @(posedge mclk) begin
      if (rst) begin
         voutMask_r  <= {2{`FSR_MASK_RST}};
         ioutMask_r  <= {2{`FSR_MASK_RST}};
         tempMask_r  <= {2{`FSR_MASK_RST}};
         makerMask_r <= {2{`FSR_MAKER_MASK_RST}};
         inputMask_r <= `FSR_MASK_RST;
         cmlMask_r   <= `FSR_MASK_RST;
      end else if (wrStb && cmdCode == `FSR_CMD_ALERT_MASK) begin
         case (cmdData[7:0])
            `FSR_CMD_VOUT_STS:  voutMask_r[cmdPage]  <= cmdData[15:8];
            `FSR_CMD_IOUT_STS:  ioutMask_r[cmdPage]  <= cmdData[15:8];
            `FSR_CMD_TEMP_STS:  tempMask_r[cmdPage]  <= cmdData[15:8];
            `FSR_CMD_MAKER_STS: makerMask_r[cmdPage] <= cmdData[15:8];
            `FSR_CMD_INPUT_STS: inputMask_r          <= cmdData[15:8];
            `FSR_CMD_CML_STS:   cmlMask_r            <= cmdData[15:8];
            default:            cmlMask_r            <= cmlMask_r;
         endcase
      end
   end

   assign alertNew  = |newVec;
   assign alertHeld = |heldVec;

   // Alert: new unmasked bit sets it, clear-faults or no held bit drops it
   always_ff @(posedge mclk) begin
      if (rst) begin
         alertActive_r <= 1'b0;
      end else begin
         alertActive_r <= alertNew
                       || (alertActive_r && alertHeld && !clearFaults);
      end
   end

   assign padWord = {rail3v3Ov, rail3v3Uv, 2'b00, adcInvalid, syncOutOff,
                     powerGood, runDriveLow, runLvl, gpioDriveLow,
                     faultLvl};
   assign commonByte = {!alertActive_r, !ctrlBusy, !calcPending,
                        !outInTransition, nvmInitDone, 1'b0,
                        sharedClkTimeout, wpLvl};

   always_comb begin
      case (cmdData[7:0])
         `FSR_CMD_VOUT_STS:  maskRead = voutMask_r[cmdPage];
         `FSR_CMD_IOUT_STS:  maskRead = ioutMask_r[cmdPage];
         `FSR_CMD_TEMP_STS:  maskRead = tempMask_r[cmdPage];
         `FSR_CMD_MAKER_STS: maskRead = makerMask_r[cmdPage];
         `FSR_CMD_INPUT_STS: maskRead = inputMask_r;
         `FSR_CMD_CML_STS:   maskRead = cmlMask_r;
         default:            maskRead = 8'h00;
      endcase
   end

   always_comb begin
      case (cmdCode)
         `FSR_CMD_SUMMARY_BYTE: rdNxt = {8'h00, sumByte[cmdPage]};
         `FSR_CMD_SUMMARY_WORD: rdNxt = sumWord[cmdPage];
         `FSR_CMD_VOUT_STS:     rdNxt = {8'h00, vout[cmdPage]};
         `FSR_CMD_IOUT_STS:     rdNxt = {8'h00, iout[cmdPage]};
         `FSR_CMD_INPUT_STS:    rdNxt = {8'h00, inputSts};
         `FSR_CMD_TEMP_STS:     rdNxt = {8'h00, temp[cmdPage]};
         `FSR_CMD_CML_STS:      rdNxt = {8'h00, comm_memory_logic_flag};
         `FSR_CMD_MAKER_STS:    rdNxt = {8'h00, makerSh | makerPg[cmdPage]};
         `FSR_CMD_PAD_STATE:    rdNxt = padWord;
         `FSR_CMD_COMMON_STS:   rdNxt = {8'h00, commonByte};
         `FSR_CMD_ALERT_MASK:   rdNxt = {8'h00, maskRead};
         default:               rdNxt = 16'h0000;
      endcase
   end

   // Read answer one cycle after the request
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdValid_r <= 1'b0;
         rdData_r  <= 16'h0000;
      end else begin
         rdValid_r <= cmdValid && !cmdWrite;
         if (cmdValid && !cmdWrite) begin
            rdData_r <= rdNxt;
         end
      end
   end

   sequence s_wrCode(logic [7:0] code);
      cmdValid && cmdWrite && cmdCode == code;
   endsequence

   word_low_a : assert property (@(posedge mclk) disable iff (rst)
      sumWord[0][7:0] == sumByte[0])
      else $error("summary word low byte differs");
   word_high_a : assert property (@(posedge mclk) disable iff (rst)
      sumWord[1][15] == |vout[1] && sumWord[1][14] == |iout[1])
      else $error("summary category bit wrong");
   pgood_inv_a : assert property (@(posedge mclk) disable iff (rst)
      sumWord[0][11] != powerGood[0])
      else $error("power good bit not inverted");
   unsup_zero_a : assert property (@(posedge mclk) disable iff (rst)
      sumWord[0][10:8] == 3'b000 && vout[0][0] == 1'b0
      && (iout[1] & ~`FSR_IOUT_SUPPORT) == 8'h00)
      else $error("unsupported bit set");
   alert_rise_a : assert property (@(posedge mclk) disable iff (rst)
      alertNew |=> alertActive_r)
      else $error("alert missed new fault");
   input_alert_a : assert property (@(posedge mclk) disable iff (rst)
      (inputEvt[5] && !inputSts[5] && newVec[14:9] == 6'h00
       && newVec[7:0] == 8'h00 && !newVec[8] && !alertActive_r)
      |=> !alertActive_r)
      else $error("input warning raised alert");
   log_keep_a : assert property (@(posedge mclk) disable iff (rst)
      (makerSh[`FSR_LOG_BIT] && !logClear) |=> makerSh[`FSR_LOG_BIT])
      else $error("fault log bit cleared without log clear");
   clr_release_a : assert property (@(posedge mclk) disable iff (rst)
      s_wrCode(`FSR_CMD_CLEAR_FAULTS) ##0 !alertNew |=> !alertActive_r)
      else $error("clear faults left alert asserted");
   mask_default_a : assert property (@(posedge mclk)
      rst |=> makerMask_r[0] == `FSR_MAKER_MASK_RST)
      else $error("maker mask reset value wrong");
   common_alert_a : assert property (@(posedge mclk) disable iff (rst)
      commonByte[7] == !alertActive_r)
      else $error("common byte alert bit wrong");
   read_lat_a : assert property (@(posedge mclk) disable iff (rst)
      cmdValid && !cmdWrite && cmdCode == `FSR_CMD_PAD_STATE
      |=> rdValid_r && rdData_r == $past(padWord))
      else $error("pad word read wrong");

endmodule : fsr_bank

// [testbench/fsr_host_model.sv]
// Host model of the status command port: one command at a time.
// Assumes it is called from the bench at falling edges of mclk.
`timescale 1ns/10ps

module fsr_host_model (
   // Clock
   input  wire logic        mclk,
   // Command port
   output logic             cmdValid,
   output logic             cmdWrite,
   output logic [7:0]       cmdCode,
   output logic             cmdPage,
   output logic [15:0]      cmdData,
   // Answer
   input  wire logic        rdValid_r,
   input  wire logic [15:0] rdData_r
);
   initial begin
      {cmdValid, cmdWrite, cmdPage} = 3'h0;
      cmdCode = 8'h00;
      cmdData = 16'h0000;
   end

   // Held for one taking edge; answer sampled the cycle after it
   task automatic xfer(input logic w, input logic [7:0] c, input logic p,
                       input logic [15:0] d, output logic [15:0] q);
      @(negedge mclk);
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdCode  = c;
      cmdPage  = p;
      cmdData  = d;
      @(negedge mclk);
      q = (rdValid_r === 1'b1) ? rdData_r : 16'hDEAD;
      cmdValid = 1'b0;
      cmdCode  = ~c;
      cmdData  = ~d;
   endtask : xfer
endmodule : fsr_host_model

// [testbench/tb_fsr_bank.sv]
// Self-checking bench of the fault and status register bank.
// Assumes the host model drives commands; events driven here.
`timescale 1ns/10ps

module tb_fsr_bank;
   localparam logic [7:0] VOUT = fsr_pkg::CMD_VOUT_STS;
   localparam logic [7:0] IOUT = fsr_pkg::CMD_IOUT_STS;
   localparam logic [7:0] INP = fsr_pkg::CMD_INPUT_STS;
   localparam logic [7:0] TEMP = fsr_pkg::CMD_TEMP_STS;
   localparam logic [7:0] CMLS = fsr_pkg::CMD_CML_STS;
   localparam logic [7:0] MAKR = fsr_pkg::CMD_MAKER_STS;
   localparam logic [7:0] WORD = fsr_pkg::CMD_SUMMARY_WORD;
   localparam logic [7:0] BYTE = fsr_pkg::CMD_SUMMARY_BYTE;
   localparam logic [7:0] CLR = fsr_pkg::CMD_CLEAR_FAULTS;
   localparam logic [7:0] PAD = fsr_pkg::CMD_PAD_STATE;
   localparam logic [7:0] COMN = fsr_pkg::CMD_COMMON_STS;
   logic            mclk, rst, cmdValid, cmdWrite, cmdPage, rdValid_r;
   logic            alertActive_r, busyEvt, rail3v3Ov, rail3v3Uv;
   logic            adcInvalid, syncOutOff, ctrlBusy, calcPending;
   logic            outInTransition, nvmInitDone, sharedClkTimeout;
   logic            writeProtPin;
   logic [7:0]      cmdCode, inputEvt, cmlEvt, makerEvt;
   logic [15:0]     cmdData, rdData_r, q, m;
   logic [1:0][7:0] voutEvt, ioutEvt, tempEvt;
   logic [1:0]      powerGood, outputOn, runDriveLow, gpioDriveLow;
   logic [1:0]      runPin, faultPin;
   int              errCount, samplesChecked;

   fsr_bank dut_u (.mclk, .rst, .cmdValid, .cmdWrite, .cmdCode, .cmdPage,
      .cmdData, .rdValid_r, .rdData_r, .alertActive_r, .voutEvt, .ioutEvt,
      .tempEvt, .inputEvt, .cmlEvt, .makerEvt, .busyEvt, .powerGood,
      .outputOn, .rail3v3Ov, .rail3v3Uv, .adcInvalid, .syncOutOff,
      .runDriveLow, .gpioDriveLow, .ctrlBusy, .calcPending,
      .outInTransition, .nvmInitDone, .sharedClkTimeout, .runPin,
      .faultPin, .writeProtPin);
   fsr_host_model host_u (.mclk, .cmdValid, .cmdWrite, .cmdCode, .cmdPage,
      .cmdData, .rdValid_r, .rdData_r);

   always #10 mclk = ~mclk;

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      samplesChecked++;
      if (s !== e) begin
         errCount++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask : tick

   task automatic rd(input logic [7:0] c, input logic p,
                     input logic [15:0] e);
      host_u.xfer(1'b0, c, p, 16'h0000, q);
      chk(q, e);
   endtask : rd

   task automatic wr(input logic [7:0] c, input logic p,
                     input logic [15:0] d);
      host_u.xfer(1'b1, c, p, d, q);
      tick(1);
   endtask : wr

   // Events set at this edge are latched, then dropped
   task automatic settle();
      tick(1);
      {voutEvt, ioutEvt, tempEvt, inputEvt, cmlEvt, makerEvt} = '0;
      busyEvt = 1'b0;
      tick(2);
   endtask : settle

   task automatic alrt(input logic e);
      chk(16'(alertActive_r), 16'(e));
   endtask : alrt

   task automatic done(input string n);
      $display("test %s ended, mismatches so far %0d", n, errCount);
   endtask : done

   task automatic conclude();
      $display("checked %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge mclk);
      errCount++;
      conclude();
   end

   initial begin
      {mclk, rst} = 2'b01;
      {voutEvt, ioutEvt, tempEvt, inputEvt, cmlEvt, makerEvt} = '0;
      {busyEvt, rail3v3Ov, rail3v3Uv, adcInvalid, syncOutOff} = '0;
      {ctrlBusy, calcPending, outInTransition, nvmInitDone} = '0;
      {sharedClkTimeout, writeProtPin, runDriveLow, gpioDriveLow} = '0;
      {powerGood, outputOn, faultPin, runPin} = 8'hFC;
      tick(8);
      rst = 1'b0;
      rd(VOUT, 1'b0, 16'h0000);
      rd(MAKR, 1'b1, 16'h0000);
      rd(8'h55, 1'b0, 16'h0000);
      alrt(1'b0);
      done("reset");
      for (int i = 1; i < 8; i++) begin
         m = 16'(8'h01 << i);
         voutEvt[0] = m[7:0];
         settle();
         alrt(1'b1);
         rd(VOUT, 1'b0, m);
         rd(WORD, 1'b0, (i == 7) ? 16'h8020 : 16'h8000);
         rd(BYTE, 1'b0, (i == 7) ? 16'h0020 : 16'h0000);
         wr(VOUT, 1'b0, 16'h0000);
         rd(VOUT, 1'b0, m);
         wr(VOUT, 1'b0, m);
         alrt(1'b0);
         rd(VOUT, 1'b0, 16'h0000);
      end
      voutEvt[0] = 8'h01;
      settle();
      rd(VOUT, 1'b0, 16'h0000);
      alrt(1'b0);
      done("vout");
      ioutEvt[1] = 8'hFF;
      busyEvt = 1'b1;
      settle();
      rd(IOUT, 1'b1, 16'h00A0);
      rd(WORD, 1'b1, 16'h4090);
      wr(IOUT, 1'b1, 16'h0080);
      rd(IOUT, 1'b1, 16'h0020);
      wr(CLR, 1'b0, 16'h0000);
      rd(WORD, 1'b1, 16'h0000);
      alrt(1'b0);
      done("iout");
      inputEvt = 8'h2A;
      settle();
      alrt(1'b0);
      rd(INP, 1'b0, 16'h002A);
      rd(WORD, 1'b0, 16'h2001);
      inputEvt = 8'h80;
      settle();
      alrt(1'b1);
      wr(INP, 1'b0, 16'h0080);
      alrt(1'b0);
      rd(INP, 1'b0, 16'h002A);
      wr(CLR, 1'b0, 16'h0000);
      done("input");
      tempEvt[0] = 8'hFF;
      cmlEvt = 8'h01;
      settle();
      rd(TEMP, 1'b0, 16'h00D0);
      rd(CMLS, 1'b0, 16'h0001);
      rd(BYTE, 1'b0, 16'h0006);
      wr(TEMP, 1'b0, 16'h0040);
      rd(TEMP, 1'b0, 16'h0090);
      wr(CLR, 1'b0, 16'h0000);
      wr(fsr_pkg::CMD_ALERT_MASK, 1'b0, 16'h407D);
      host_u.xfer(1'b0, fsr_pkg::CMD_ALERT_MASK, 1'b0, 16'h007D, q);
      chk(q, 16'h0040);
      tempEvt[0] = 8'h40;
      settle();
      alrt(1'b0);
      rd(TEMP, 1'b0, 16'h0040);
      wr(CLR, 1'b0, 16'h0000);
      done("temp");
      makerEvt = 8'hF8;
      settle();
      alrt(1'b1);
      rd(MAKR, 1'b0, 16'h00F8);
      rd(MAKR, 1'b1, 16'h00F8);
      rd(WORD, 1'b1, 16'h1000);
      wr(MAKR, 1'b0, 16'h00FF);
      rd(MAKR, 1'b1, 16'h0008);
      wr(fsr_pkg::CMD_FAULT_LOG_CLR, 1'b0, 16'h0000);
      rd(MAKR, 1'b0, 16'h0000);
      makerEvt = 8'h10;
      settle();
      alrt(1'b0);
      rd(MAKR, 1'b0, 16'h0010);
      wr(CLR, 1'b0, 16'h0000);
      faultPin = 2'b01;
      tick(4);
      rd(MAKR, 1'b1, 16'h0001);
      rd(MAKR, 1'b0, 16'h0000);
      alrt(1'b0);
      faultPin = 2'b11;
      tick(3);
      wr(CLR, 1'b0, 16'h0000);
      done("maker");
      voutEvt[1] = 8'h80;
      tick(2);
      wr(CLR, 1'b0, 16'h0000);
      rd(VOUT, 1'b1, 16'h0080);
      alrt(1'b1);
      voutEvt = '0;
      wr(CLR, 1'b0, 16'h0000);
      done("refault");
      {rail3v3Ov, adcInvalid, ctrlBusy, outInTransition} = 4'hF;
      {nvmInitDone, sharedClkTimeout, writeProtPin} = 3'h7;
      {runDriveLow, gpioDriveLow, runPin, powerGood} = 8'h69;
      outputOn = 2'b10;
      tick(4);
      rd(PAD, 1'b0, 16'h896B);
      wr(PAD, 1'b0, 16'h0000);
      rd(PAD, 1'b0, 16'h896B);
      alrt(1'b1);
      rd(COMN, 1'b0, 16'h002B);
      rd(WORD, 1'b1, 16'h1800);
      rd(WORD, 1'b0, 16'h1040);
      {rail3v3Ov, adcInvalid, ctrlBusy, outInTransition} = 4'h0;
      {sharedClkTimeout, writeProtPin, powerGood, outputOn} = 6'h0F;
      tick(2);
      wr(CLR, 1'b0, 16'h0000);
      rd(COMN, 1'b0, 16'h00F8);
      done("pads");
      conclude();
   end
endmodule : tb_fsr_bank
